/* File: pal_defines.svh */
`ifndef PAL_DEFINES_SVH
`define PAL_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PAL_OFF_CTRL 12'h000
`define PAL_OFF_OVR 12'h004
`define PAL_OFF_STAT 12'h008

// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define PAL_CTRL_BYPASS 0
`define PAL_CTRL_FWB 1
`define PAL_CTRL_OVR 2
`define PAL_CTRL_MATCH 3
`define PAL_CTRL_OSH 4
`define PAL_CTRL_RST 5'h00
`define PAL_OVR_RST 7'h00

// ----------------------------------------
// Attribute encodings
// ----------------------------------------
`define PAL_CACHE_NC 2'h0
`define PAL_CACHE_WB 2'h2
`define PAL_SH_OSH 2'h2
`define PAL_SH_ISH 2'h3

// ----------------------------------------
// Attribute field in a translated address
// ----------------------------------------
`define PAL_ATS_MARK 63
`define PAL_ATS_HI 62
`define PAL_ATS_LO 56
`define PAL_ATS_PA_HI 55
`define PAL_N_FIELD 1'h0

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define PAL_RESP_OKAY 2'h0
`define PAL_RESP_SLVERR 2'h2

`endif

/* File: pal_pkg.sv */
package pal_pkg;

  typedef enum logic [1:0] {
    pal_kind_untr,
    pal_kind_trans,
    pal_kind_atsreq
  } pal_kind_t;

  typedef struct packed {
    logic normal;
    logic [1:0] icache;
    logic [1:0] ocache;
    logic [1:0] sh;
  } pal_attr_t;

  typedef struct packed {
    pal_kind_t kind;
    logic [63:0] addr;
    logic no_snoop;
    logic dev_target;
    pal_attr_t in_attr;
    logic desc_hit;
    pal_attr_t desc_attr;
    logic [63:0] desc_pa;
    logic s2_force_wb;
  } pal_req_t;

  typedef struct packed {
    pal_kind_t kind;
    logic [63:0] addr;
    pal_attr_t attr;
    logic no_snoop;
    logic n_field;
  } pal_rsp_t;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } pal_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pal_axi_rsp_t;

  typedef struct packed {
    logic [4:0] ctrl;
    pal_attr_t ovr;
    logic [15:0] ns_count;
    logic aw_got;
    logic [11:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic b_valid;
    logic [1:0] b_resp;
    logic r_valid;
    logic [31:0] r_data;
    logic [1:0] r_resp;
    logic s1_valid;
    pal_kind_t s1_kind;
    logic [63:0] s1_addr;
    pal_attr_t s1_attr;
    logic s1_ns;
    logic s2_valid;
    pal_rsp_t s2_out;
  } pal_st_t;

endpackage

/* File: pal_attr.sv */
`timescale 1ns/10ps
`include "pal_defines.svh"

// Behaviour
// - Bypass sends memory traffic fixed cached shared.
// - Device targets such as MSIs become Device.
// - Untranslated output combines input, overrides, descriptors.
// - Override use for PCIe is a build parameter.
// - No_snoop downgrades Normal cacheable to iNC-oNC-OSH.
// - No_snoop leaves Device attributes unchanged.
// - No_snoop acts after stage 2 forced writeback.
// - No_snoop flag travels alongside through the pipeline.
// - Translated traffic skips translation, descriptor attribute not applied.
// - Translated attribute: matching or fixed, selectable.
// - Attribute encoded in unused translated address bits.
// - Encoded attribute ignores any later No_snoop downgrade.
// - Completion N field is always zero.
// - No per-page No_snoop control exists.
module pal_attr #(
  parameter bit NOSNOOP_EN = 1'b1,
  parameter bit ATS_ATTR_EN = 1'b1,
  parameter bit PCIE_OVR_EN = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire pal_pkg::pal_axi_req_t axi_req,
  output pal_pkg::pal_axi_rsp_t axi_rsp,
  input wire logic txn_valid,
  output logic txn_ready,
  input wire pal_pkg::pal_req_t txn,
  output logic out_valid,
  input wire logic out_ready,
  output pal_pkg::pal_rsp_t out_txn
);

  // ----------------------------------------
  // Attribute helpers
  // ----------------------------------------
  function automatic pal_pkg::pal_attr_t fix_attr(input logic osh);
    pal_pkg::pal_attr_t r;
    r.normal = 1'b1;
    r.icache = `PAL_CACHE_WB;
    r.ocache = `PAL_CACHE_WB;
    r.sh = osh ? `PAL_SH_OSH : `PAL_SH_ISH;
    return r;
  endfunction

  // Non-cached outer shareable; Device uses the same cache fields.
  function automatic pal_pkg::pal_attr_t nc_attr(input logic normal);
    pal_pkg::pal_attr_t r;
    r.normal = normal;
    r.icache = `PAL_CACHE_NC;
    r.ocache = `PAL_CACHE_NC;
    r.sh = `PAL_SH_OSH;
    return r;
  endfunction

  // The weaker cacheability wins, and any Device input gives Device.
  function automatic pal_pkg::pal_attr_t combine(input pal_pkg::pal_attr_t a,
                                                 input pal_pkg::pal_attr_t b);
    pal_pkg::pal_attr_t r;
    r = b;
    if (!a.normal || !b.normal) begin
      r = nc_attr(1'b0);
    end else begin
      r.icache = (a.icache < b.icache) ? a.icache : b.icache;
      r.ocache = (a.ocache < b.ocache) ? a.ocache : b.ocache;
      r.sh = (a.sh == `PAL_SH_OSH) ? `PAL_SH_OSH : b.sh;
    end
    return r;
  endfunction

  function automatic logic cacheable(input pal_pkg::pal_attr_t a);
    return a.normal && (a.icache != `PAL_CACHE_NC || a.ocache != `PAL_CACHE_NC);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  pal_pkg::pal_st_t q;
  pal_pkg::pal_st_t n;
  logic s2_go;
  logic s1_go;
  logic acc;
  logic aw_ready;
  logic w_ready;
  logic ctrl_osh;
  logic fwb_hit;

  assign s2_go = !q.s2_valid || out_ready;
  assign s1_go = !q.s1_valid || s2_go;
  assign acc = txn_valid && s1_go;
  assign aw_ready = !q.aw_got && !q.b_valid;
  assign w_ready = !q.w_got && !q.b_valid;
  assign ctrl_osh = q.ctrl[`PAL_CTRL_OSH];
  assign fwb_hit = txn.desc_hit && txn.s2_force_wb && q.ctrl[`PAL_CTRL_FWB] &&
                   !q.ctrl[`PAL_CTRL_BYPASS];

  assign txn_ready = s1_go;
  assign out_valid = q.s2_valid;
  assign out_txn = q.s2_out;
  assign axi_rsp.awready = aw_ready;
  assign axi_rsp.wready = w_ready;
  assign axi_rsp.bvalid = q.b_valid;
  assign axi_rsp.bresp = q.b_resp;
  assign axi_rsp.arready = !q.r_valid;
  assign axi_rsp.rvalid = q.r_valid;
  assign axi_rsp.rdata = q.r_data;
  assign axi_rsp.rresp = q.r_resp;

  always_comb begin
    pal_pkg::pal_attr_t a;
    logic [63:0] ad;
    logic dn;
    a = txn.in_attr;
    ad = txn.addr;
    dn = 1'b0;
    n = q;

    // ----------------------------------------
    // Register slave
    // ----------------------------------------
    if (axi_req.awvalid && aw_ready) begin
      n.aw_got = 1'b1;
      n.aw_addr = axi_req.awaddr[11:0];
    end
    if (axi_req.wvalid && w_ready) begin
      n.w_got = 1'b1;
      n.w_data = axi_req.wdata;
      n.w_strb = axi_req.wstrb;
    end
    // The write lands one cycle after both halves are held.
    if (q.aw_got && q.w_got && !q.b_valid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.b_valid = 1'b1;
      n.b_resp = `PAL_RESP_OKAY;
      unique case (q.aw_addr)
        `PAL_OFF_CTRL: begin
          if (q.w_strb[0]) begin
            n.ctrl = q.w_data[4:0];
          end
        end
        `PAL_OFF_OVR: begin
          if (q.w_strb[0]) begin
            n.ovr = pal_pkg::pal_attr_t'(q.w_data[6:0]);
          end
        end
        `PAL_OFF_STAT: begin
        end
        default: begin
          n.b_resp = `PAL_RESP_SLVERR;
        end
      endcase
    end
    if (q.b_valid && axi_req.bready) begin
      n.b_valid = 1'b0;
    end
    if (axi_req.arvalid && !q.r_valid) begin
      n.r_valid = 1'b1;
      n.r_resp = `PAL_RESP_OKAY;
      unique case (axi_req.araddr[11:0])
        `PAL_OFF_CTRL: n.r_data = {27'h000_0000, q.ctrl};
        `PAL_OFF_OVR: n.r_data = {25'h000_0000, q.ovr};
        `PAL_OFF_STAT: n.r_data = {14'h0000, q.s2_valid, q.s1_valid, q.ns_count};
        default: begin
          n.r_data = 32'h0000_0000;
          n.r_resp = `PAL_RESP_SLVERR;
        end
      endcase
    end
    if (q.r_valid && axi_req.rready) begin
      n.r_valid = 1'b0;
    end

    // ----------------------------------------
    // Stage 1: attribute calculation
    // ----------------------------------------
    // The upstream attribute is trusted to be the fixed cacheable shared one.
    // override replaces incoming attribute
    if (PCIE_OVR_EN && q.ctrl[`PAL_CTRL_OVR]) begin
      a = q.ovr;
    end
    unique case (txn.kind)
      pal_pkg::pal_kind_trans: begin
        a = fix_attr(ctrl_osh);
        if (ATS_ATTR_EN && q.ctrl[`PAL_CTRL_MATCH] && txn.addr[`PAL_ATS_MARK]) begin
          a = pal_pkg::pal_attr_t'(txn.addr[`PAL_ATS_HI:`PAL_ATS_LO]);
          ad = {8'h00, txn.addr[`PAL_ATS_PA_HI:0]};
        end
      end
      pal_pkg::pal_kind_untr, pal_pkg::pal_kind_atsreq: begin
        if (q.ctrl[`PAL_CTRL_BYPASS]) begin
          a = fix_attr(ctrl_osh);
        end else if (txn.desc_hit) begin
          a = combine(a, txn.desc_attr);
          ad = txn.desc_pa;
        end
        if (fwb_hit && a.normal) begin
          a.icache = `PAL_CACHE_WB;
          a.ocache = `PAL_CACHE_WB;
        end
      end
      default: begin
        a = nc_attr(1'b0);
      end
    endcase
    if (txn.dev_target) begin
      a = nc_attr(1'b0);
    end
    if (ATS_ATTR_EN && txn.kind == pal_pkg::pal_kind_atsreq) begin
      ad = {1'b1, a, ad[`PAL_ATS_PA_HI:0]};
    end
    if (s1_go) begin
      n.s1_valid = txn_valid;
      if (txn_valid) begin
        n.s1_kind = txn.kind;
        n.s1_addr = ad;
        n.s1_attr = a;
        n.s1_ns = txn.no_snoop;
      end
    end

    // ----------------------------------------
    // Stage 2: No_snoop downgrade at the output
    // ----------------------------------------
    // Completions are not memory accesses, so the downgrade never applies to them; the flag still travels.
    // cacheable downgrade
    dn = NOSNOOP_EN && q.s1_ns && q.s1_kind != pal_pkg::pal_kind_atsreq &&
         cacheable(q.s1_attr);
    if (s2_go) begin
      n.s2_valid = q.s1_valid;
      if (q.s1_valid) begin
        n.s2_out.kind = q.s1_kind;
        n.s2_out.addr = q.s1_addr;
        n.s2_out.attr = dn ? nc_attr(1'b1) : q.s1_attr;
        n.s2_out.no_snoop = q.s1_ns;
        n.s2_out.n_field = `PAL_N_FIELD;
        if (dn) begin
          n.ns_count = q.ns_count + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.ctrl <= `PAL_CTRL_RST;
      q.ovr <= `PAL_OVR_RST;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  bypass_fixed_a: assert property (@(posedge aclk) disable iff (!aresetn)
    acc && txn.kind == pal_pkg::pal_kind_untr && !txn.dev_target &&
    q.ctrl[`PAL_CTRL_BYPASS] && !q.ctrl[`PAL_CTRL_FWB]
    |=> q.s1_attr == fix_attr($past(ctrl_osh)))
    else $error("bypass attribute not fixed cached shared");

  device_target_a: assert property (@(posedge aclk) disable iff (!aresetn)
    acc && txn.dev_target |=> !q.s1_attr.normal ##0 q.s1_valid)
    else $error("device target not Device type");

  nosnoop_down_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s2_go && q.s1_valid && NOSNOOP_EN && q.s1_ns && cacheable(q.s1_attr) &&
    q.s1_kind != pal_pkg::pal_kind_atsreq
    |=> out_valid && out_txn.attr == nc_attr(1'b1))
    else $error("no snoop downgrade missing");

  device_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s2_go && q.s1_valid && !q.s1_attr.normal |=> out_txn.attr == $past(q.s1_attr))
    else $error("Device attribute altered");

  fwb_first_a: assert property (@(posedge aclk) disable iff (!aresetn)
    acc && fwb_hit && !txn.dev_target && txn.kind == pal_pkg::pal_kind_untr &&
    txn.desc_attr.normal && txn.in_attr.normal
    |=> q.s1_attr.icache == `PAL_CACHE_WB && q.s1_attr.ocache == `PAL_CACHE_WB)
    else $error("forced writeback not applied before output stage");

  ns_carry_a: assert property (@(posedge aclk) disable iff (!aresetn)
    acc ##1 s2_go |=> out_txn.no_snoop == $past(q.s1_ns) ##0 out_valid)
    else $error("no snoop flag lost in pipeline");

  trans_addr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    acc && txn.kind == pal_pkg::pal_kind_trans && !txn.addr[`PAL_ATS_MARK]
    |=> q.s1_addr == $past(txn.addr) && q.s1_attr.normal == !$past(txn.dev_target))
    else $error("translated address changed");

  ats_encode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    out_valid && ATS_ATTR_EN && out_txn.kind == pal_pkg::pal_kind_atsreq
    |-> out_txn.addr[`PAL_ATS_MARK] &&
    out_txn.addr[`PAL_ATS_HI:`PAL_ATS_LO] == out_txn.attr)
    else $error("completion attribute not encoded");

  n_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    out_valid && out_txn.kind == pal_pkg::pal_kind_atsreq |-> out_txn.n_field == 1'b0)
    else $error("completion N field set");

  out_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    out_valid && !out_ready |=> out_valid && $stable(out_txn))
    else $error("output dropped while stalled");

  bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped");

  rdata_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped");

  ats_strip_a: assert property (@(posedge aclk) disable iff (!aresetn)
    acc && txn.kind == pal_pkg::pal_kind_trans && ATS_ATTR_EN &&
    q.ctrl[`PAL_CTRL_MATCH] && txn.addr[`PAL_ATS_MARK]
    |=> q.s1_addr == {8'h00, $past(txn.addr[`PAL_ATS_PA_HI:0])})
    else $error("translated address field not stripped");

  trans_fixed_a: assert property (@(posedge aclk) disable iff (!aresetn)
    acc && txn.kind == pal_pkg::pal_kind_trans && !txn.dev_target &&
    !(q.ctrl[`PAL_CTRL_MATCH] && txn.addr[`PAL_ATS_MARK])
    |=> q.s1_attr == fix_attr($past(ctrl_osh)))
    else $error("translated attribute not fixed");

  attr_pass_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s2_go && q.s1_valid && !q.s1_ns |=> out_txn.attr == $past(q.s1_attr))
    else $error("attribute changed without no snoop flag");

endmodule

/* File: pal_rc_model.sv */
`timescale 1ns/10ps
module pal_rc_model (
  input wire logic aclk,
  input wire logic req_v,
  input wire pal_pkg::pal_req_t req,
  input wire logic slow,
  output logic txn_valid,
  output pal_pkg::pal_req_t txn,
  output logic out_ready
);
  logic tgl_q = 1'b0;

  // Slow mode stalls the memory side on every other cycle.
  always @(posedge aclk) tgl_q <= ~tgl_q;
  assign out_ready = !slow || tgl_q;

  always_comb begin
    txn = req;
    txn.in_attr = 7'h6B;
    // An idle payload has its address inverted, so a stale value cannot pass for a request.
    if (!req_v) begin
      txn.addr = ~req.addr;
    end
    txn_valid = req_v;
  end
endmodule

/* File: pal_attr_tb.sv */
`timescale 1ns/10ps
module pal_attr_tb;
  localparam logic [6:0] WBI = 7'h6B;
  localparam logic [6:0] WBO = 7'h6A;
  localparam logic [6:0] NCA = 7'h42;
  localparam logic [1:0] OK = 2'h0;
  localparam logic [1:0] ER = 2'h2;
  localparam logic N = 1'b0;
  localparam logic Y = 1'b1;
  localparam logic [63:0] A = 64'h0000_0012_3456_7000;
  localparam logic [63:0] D = 64'h0000_0100_0000_0000;
  localparam pal_pkg::pal_kind_t UT = pal_pkg::pal_kind_untr;
  localparam pal_pkg::pal_kind_t TR = pal_pkg::pal_kind_trans;
  localparam pal_pkg::pal_kind_t AR = pal_pkg::pal_kind_atsreq;
  logic aclk;
  logic aresetn;
  logic rv;
  logic slow;
  logic txn_valid;
  logic txn_ready;
  logic out_valid;
  logic out_ready;
  logic [63:0] e;
  pal_pkg::pal_axi_req_t axi_req;
  pal_pkg::pal_axi_rsp_t axi_rsp;
  pal_pkg::pal_req_t rq;
  pal_pkg::pal_req_t txn;
  pal_pkg::pal_rsp_t out_txn;
  pal_pkg::pal_rsp_t o;
  pal_pkg::pal_rsp_t q[$];
  int n_fail = 0;
  int num_checks = 0;

  pal_attr u_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .txn_valid(txn_valid), .txn_ready(txn_ready), .txn(txn), .out_valid(out_valid),
    .out_ready(out_ready), .out_txn(out_txn));
  pal_rc_model u_rc (.aclk(aclk), .req_v(rv), .req(rq), .slow(slow), .txn_valid(txn_valid),
    .txn(txn), .out_ready(out_ready));

  always #20 aclk = ~aclk;
  // Sampled at the falling edge, so the handshake of the next rising edge is settled.
  always @(negedge aclk) if (out_valid && out_ready) q.push_back(out_txn);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [63:0] s, input logic [63:0] x);
    num_checks++;
    if (s !== x) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic b;
    logic aw;
    logic w;
    b = 1'b0;
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    while (!b) begin
      @(negedge aclk);
      aw = axi_rsp.awready;
      w = axi_rsp.wready;
      b = axi_rsp.bvalid;
      if (b) chk(64'(axi_rsp.bresp), 64'(er));
      @(posedge aclk);
      if (aw) axi_req.awvalid <= 1'b0;
      if (w) axi_req.wvalid <= 1'b0;
    end
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic r;
    logic ar;
    r = 1'b0;
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    while (!r) begin
      @(negedge aclk);
      ar = axi_rsp.arready;
      r = axi_rsp.rvalid;
      if (r) chk(64'({axi_rsp.rresp, axi_rsp.rdata}), 64'({er, d}));
      @(posedge aclk);
      if (ar) axi_req.arvalid <= 1'b0;
    end
  endtask

  function automatic pal_pkg::pal_req_t mk(pal_pkg::pal_kind_t k, logic [63:0] a,
      logic ns, logic dv, logic [6:0] da, logic fw);
    mk = '0;
    mk.kind = k;
    mk.addr = a;
    mk.no_snoop = ns;
    mk.dev_target = dv;
    mk.desc_hit = (da != 7'h00);
    mk.desc_attr = da;
    mk.desc_pa = a + D;
    mk.s2_force_wb = fw;
  endfunction

  task automatic put(input pal_pkg::pal_req_t r);
    logic t;
    t = 1'b0;
    rq <= r;
    rv <= 1'b1;
    while (!t) begin
      @(negedge aclk);
      t = txn_ready;
      @(posedge aclk);
    end
  endtask

  task automatic get();
    int n;
    n = 0;
    while (q.size() == 0 && n < 40) begin
      @(posedge aclk);
      n++;
    end
    o = '0;
    chk(64'(q.size() != 0), 64'h1);
    if (q.size() != 0) o = q.pop_front();
  endtask

  task automatic ck(input pal_pkg::pal_req_t r, input logic [6:0] at, input logic [63:0] ad);
    put(r);
    rv <= 1'b0;
    get();
    chk(64'(o.attr), 64'(at));
    chk(o.addr, ad);
    chk(64'(o.kind), 64'(r.kind));
    chk(64'(o.n_field), 64'h0);
    chk(64'(o.no_snoop), 64'(r.no_snoop));
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd(32'h0, 32'h0, OK);
    rd(32'h4, 32'h0, OK);
    rd(32'h8, 32'h0, OK);
    rd(32'hC, 32'h0, ER);
    wr(32'h10, 32'h1, ER);
    wr(32'h8, 32'hFFFF_FFFF, OK);
    rd(32'h8, 32'h0, OK);
    wr(32'h0, 32'hFFFF_FFFF, OK);
    rd(32'h0, 32'h1F, OK);
  endtask

  task automatic t_byp();
    wr(32'h0, 32'h1, OK);
    ck(mk(UT, A, N, N, 7'h02, N), WBI, A);
    ck(mk(UT, A, Y, Y, 7'h00, N), 7'h02, A);
  endtask

  task automatic t_untr();
    wr(32'h0, 32'h4, OK);
    wr(32'h4, 32'h0, OK);
    ck(mk(UT, A, N, N, 7'h62, N), 7'h62, A + D);
    ck(mk(UT, A, N, N, 7'h4B, N), 7'h4B, A + D);
    ck(mk(UT, A, N, N, 7'h00, N), WBI, A);
    ck(mk(UT, A, Y, N, 7'h00, N), NCA, A);
    rd(32'h8, 32'h1, OK);
  endtask

  task automatic t_fwb();
    wr(32'h0, 32'h2, OK);
    ck(mk(UT, A, N, N, NCA, Y), WBO, A + D);
    ck(mk(UT, A, Y, N, NCA, Y), NCA, A + D);
    rd(32'h8, 32'h2, OK);
  endtask

  task automatic t_ats();
    wr(32'h0, 32'h18, OK);
    ck(mk(AR, A, Y, N, 7'h00, N), WBI, {1'b1, WBI, A[55:0]});
    e = o.addr;
    ck(mk(TR, e, N, N, 7'h4B, N), WBI, {8'h00, e[55:0]});
    ck(mk(TR, e, Y, N, 7'h00, N), NCA, {8'h00, e[55:0]});
    ck(mk(TR, A, N, N, 7'h4B, N), WBO, A);
    wr(32'h0, 32'h10, OK);
    ck(mk(TR, e, N, N, 7'h00, N), WBO, e);
    rd(32'h8, 32'h3, OK);
  endtask

  task automatic t_b2b();
    wr(32'h0, 32'h0, OK);
    slow <= 1'b1;
    for (int i = 0; i < 4; i++) put(mk(UT, A + 64'(i), N, N, 7'h00, N));
    rv <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      get();
      chk(o.addr, A + 64'(i));
      chk(64'(o.attr), 64'(WBI));
    end
    slow <= 1'b0;
  endtask

  task automatic print_verdict();
    if (n_fail == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    axi_req = '0;
    // Response ready stays high, so back-to-back calls never re-drive it in one step.
    axi_req.bready = 1'b1;
    axi_req.rready = 1'b1;
    rq = '0;
    rv = 1'b0;
    slow = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_byp();
    t_untr();
    t_fwb();
    t_ats();
    t_b2b();
    print_verdict();
  end

  // The whole sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge aclk);
    n_fail++;
    print_verdict();
  end
endmodule
